//--- verilog/accum_pkg.sv
// package for the 16-bit pulse accumulator: register map, fields, codes
// assumes a classic wishbone slave with 32-bit data and byte addressing
`default_nettype none
package accum_pkg;
	// ----------------------------------------------------------------
	// register indices and byte addresses (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL  = 8'h20;
	localparam logic [7:0] IDX_FLAGS = 8'h21;
	localparam logic [7:0] IDX_CNTH  = 8'h22;
	localparam logic [7:0] IDX_CNTL  = 8'h23;
	localparam logic [7:0] IDX_SYS   = 8'h24;
	localparam logic [7:0] IDX_CNTW  = 8'h25;
	localparam logic [7:0] IDX_ISTAT = 8'h26;
	localparam logic [7:0] IDX_IMASK = 8'h27;
	localparam logic [9:0] ADR_CTRL  = {IDX_CTRL, 2'b00};
	localparam logic [9:0] ADR_FLAGS = {IDX_FLAGS, 2'b00};
	localparam logic [9:0] ADR_CNTH  = {IDX_CNTH, 2'b00};
	localparam logic [9:0] ADR_CNTL  = {IDX_CNTL, 2'b00};
	localparam logic [9:0] ADR_SYS   = {IDX_SYS, 2'b00};
	localparam logic [9:0] ADR_CNTW  = {IDX_CNTW, 2'b00};
	localparam logic [9:0] ADR_ISTAT = {IDX_ISTAT, 2'b00};
	localparam logic [9:0] ADR_IMASK = {IDX_IMASK, 2'b00};
	// ----------------------------------------------------------------
	// field layouts and reset values
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       spare;
		logic       accum_enable;
		logic       accum_mode_select;
		logic       accum_edge_polarity;
		logic [1:0] clock_select;
		logic       accum_overflow_irq_en;
		logic       accum_edge_irq_en;
	} ctrl_t;
	typedef struct packed {
		logic fast_flag_clear;
		logic timer_enable_bit;
	} sys_t;
	localparam ctrl_t CTRL_RST = ctrl_t'(8'h00);
	localparam sys_t  SYS_RST  = sys_t'(2'h0);
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	localparam logic [7:0]  BYTE_MAX = 8'hFF;
	localparam int OVF_BIT  = 1;
	localparam int EDGE_BIT = 0;
	// ----------------------------------------------------------------
	// clock select codes and divider
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_PRESCALE = 2'h0;
	localparam logic [1:0] SEL_ACCUM    = 2'h1;
	localparam logic [1:0] SEL_DIV256   = 2'h2;
	localparam logic [1:0] SEL_DIV64K   = 2'h3;
	localparam int GATE_DIV = 64;
	localparam logic [5:0] GATE_LAST = 6'(GATE_DIV - 1);
endpackage
`default_nettype wire

//--- verilog/pulse_accumulator_16bit.sv
// 16-bit pulse accumulator with wishbone registers and one irq line
// assumes prescaler_tick is a synchronous input on clk; channel7_pin passes a two-stage sync
//
// Decided for this implementation: the Wishbone interface to the registers.
`default_nettype none
module pulse_accumulator_16bit (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output var  logic [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        channel7_pin,
	input  wire logic        prescaler_tick,
	output logic             timer_count_tick,
	output logic             irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	accum_pkg::ctrl_t ctrl;
	accum_pkg::sys_t  sys;
	logic [15:0] accum_count;
	logic        accum_overflow_flag;
	logic        accum_edge_flag;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic        pin_meta;
	logic        pin_sync;
	logic        pin_prev;
	logic [5:0]  gate_div;
	logic        gate_tick;
	logic        rise;
	logic        fall;
	logic        sel_edge;
	logic        gate_level;
	logic        event_mode;
	logic        gated_mode;
	logic        accum_clock;
	logic        ovf_event;
	logic        edge_event;
	logic        bus_take;
	logic        bus_wr;
	logic        bus_rd;
	logic        cnt_hit;
	logic        cnt_wr;
	logic        fast_clear_now;
	logic        flag_clr_en;
	logic        clr_ovf;
	logic        clr_edge;
	logic [15:0] next_count;
	logic [31:0] next_dat;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// input synchroniser and edge detect
	// ----------------------------------------------------------------
	// two-stage sync
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= channel7_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign rise = pin_sync & ~pin_prev;
	assign fall = ~pin_sync & pin_prev;
	assign sel_edge = ctrl.accum_edge_polarity ? rise : fall;
	assign gate_level = ctrl.accum_edge_polarity ? ~pin_sync : pin_sync;
	assign event_mode = ctrl.accum_enable & ~ctrl.accum_mode_select;
	assign gated_mode = ctrl.accum_enable & ctrl.accum_mode_select;

	// ----------------------------------------------------------------
	// divide-by-64 of clk while the timer is enabled
	// ----------------------------------------------------------------
	// divider cleared while timer off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gate_div <= 6'h00;
		end else if (!sys.timer_enable_bit) begin
			gate_div <= 6'h00;
		end else begin
			gate_div <= gate_div + 6'h01;
		end
	end

	assign gate_tick = sys.timer_enable_bit
		& (gate_div == accum_pkg::GATE_LAST);

	// ----------------------------------------------------------------
	// accumulator clock and events
	// ----------------------------------------------------------------
	// counts only while enabled
	assign accum_clock = (event_mode & sel_edge)
		| (gated_mode & gate_tick & gate_level);
	assign ovf_event = accum_clock
		& (accum_count == accum_pkg::CNT_MAX);
	assign edge_event = ctrl.accum_enable & sel_edge;

	// ----------------------------------------------------------------
	// timer counter clock select
	// ----------------------------------------------------------------
	// source mux
	always_comb begin
		timer_count_tick = prescaler_tick;
		if (ctrl.accum_enable) begin
			case (ctrl.clock_select)
				accum_pkg::SEL_PRESCALE: begin
					timer_count_tick = prescaler_tick;
				end
				accum_pkg::SEL_ACCUM: begin
					timer_count_tick = accum_clock;
				end
				accum_pkg::SEL_DIV256: begin
					timer_count_tick = accum_clock
						& (accum_count[7:0] == accum_pkg::BYTE_MAX);
				end
				accum_pkg::SEL_DIV64K: begin
					timer_count_tick = ovf_event;
				end
				default: begin
					timer_count_tick = prescaler_tick;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	assign bus_take = cyc_i & stb_i & ~ack_o;
	assign bus_wr = bus_take & we_i;
	assign bus_rd = bus_take & ~we_i;
	assign cnt_hit = (adr_i == accum_pkg::ADR_CNTH)
		| (adr_i == accum_pkg::ADR_CNTL)
		| (adr_i == accum_pkg::ADR_CNTW);
	assign cnt_wr = bus_wr & cnt_hit;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_take;
		end
	end

	always_comb begin
		next_dat = 32'h0000_0000;
		case (adr_i)
			accum_pkg::ADR_CTRL: begin
				next_dat[7:0] = ctrl;
			end
			accum_pkg::ADR_FLAGS: begin
				next_dat[accum_pkg::OVF_BIT] = accum_overflow_flag;
				next_dat[accum_pkg::EDGE_BIT] = accum_edge_flag;
			end
			accum_pkg::ADR_CNTH: begin
				next_dat[7:0] = accum_count[15:8];
			end
			accum_pkg::ADR_CNTL: begin
				next_dat[7:0] = accum_count[7:0];
			end
			accum_pkg::ADR_SYS: begin
				next_dat[1:0] = sys;
			end
			accum_pkg::ADR_CNTW: begin
				next_dat[15:0] = accum_count;
			end
			accum_pkg::ADR_ISTAT: begin
				next_dat[1:0] = irq_status;
			end
			accum_pkg::ADR_IMASK: begin
				next_dat[1:0] = irq_mask;
			end
			default: begin
				next_dat = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dat_o <= 32'h0000_0000;
		end else if (bus_rd) begin
			dat_o <= next_dat;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// enable bits held apart
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= accum_pkg::CTRL_RST;
			sys <= accum_pkg::SYS_RST;
			irq_mask <= 2'h0;
		end else if (bus_wr && sel_i[0]) begin
			if (adr_i == accum_pkg::ADR_CTRL) begin
				ctrl <= accum_pkg::ctrl_t'({1'b0, dat_i[6:0]});
			end
			if (adr_i == accum_pkg::ADR_SYS) begin
				sys <= accum_pkg::sys_t'(dat_i[1:0]);
			end
			if (adr_i == accum_pkg::ADR_IMASK) begin
				irq_mask <= dat_i[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// count register
	// ----------------------------------------------------------------
	// bus write beats the increment in the bytes it writes
	always_comb begin
		next_count = accum_count;
		if (accum_clock) begin
			next_count = accum_count + 16'h0001;
		end
		if (cnt_wr) begin
			case (adr_i)
				accum_pkg::ADR_CNTH: begin
					if (sel_i[0]) begin
						next_count[15:8] = dat_i[7:0];
					end
				end
				accum_pkg::ADR_CNTL: begin
					if (sel_i[0]) begin
						next_count[7:0] = dat_i[7:0];
					end
				end
				default: begin
					if (sel_i[0]) begin
						next_count[7:0] = dat_i[7:0];
					end
					if (sel_i[1]) begin
						next_count[15:8] = dat_i[15:8];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			accum_count <= accum_pkg::CNT_RST;
		end else begin
			accum_count <= next_count;
		end
	end

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	// any count access clears
	assign fast_clear_now = sys.fast_flag_clear & bus_take & cnt_hit;
	assign flag_clr_en = bus_wr & sel_i[0]
		& (adr_i == accum_pkg::ADR_FLAGS)
		& (sys.timer_enable_bit | ctrl.accum_enable);
	assign clr_ovf = fast_clear_now
		| (flag_clr_en & dat_i[accum_pkg::OVF_BIT]);
	assign clr_edge = fast_clear_now
		| (flag_clr_en & dat_i[accum_pkg::EDGE_BIT]);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			accum_overflow_flag <= 1'b0;
			accum_edge_flag <= 1'b0;
		end else begin
			accum_overflow_flag <= ovf_event
				| (accum_overflow_flag & ~clr_ovf);
			accum_edge_flag <= edge_event
				| (accum_edge_flag & ~clr_edge);
		end
	end

	// ----------------------------------------------------------------
	// interrupt status, read-clear, masked output
	// ----------------------------------------------------------------
	// overflow and edge requests
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_status <= 2'h0;
		end else begin
			irq_status[accum_pkg::OVF_BIT] <=
				(accum_overflow_flag & ctrl.accum_overflow_irq_en)
				| (irq_status[accum_pkg::OVF_BIT]
				& ~(bus_rd && adr_i == accum_pkg::ADR_ISTAT));
			irq_status[accum_pkg::EDGE_BIT] <=
				(accum_edge_flag & ctrl.accum_edge_irq_en)
				| (irq_status[accum_pkg::EDGE_BIT]
				& ~(bus_rd && adr_i == accum_pkg::ADR_ISTAT));
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	ack_timing_a: assert property (bus_take |=> ack_o ##1 !ack_o)
		else $error("ack not one cycle after request");
	ovf_flag_a: assert property (
		ovf_event |=> accum_overflow_flag)
		else $error("overflow flag not set on wrap");
	edge_flag_a: assert property (
		(ctrl.accum_enable && pin_prev && !pin_sync
		&& !ctrl.accum_edge_polarity) |=> accum_edge_flag)
		else $error("edge flag not set on falling edge");
	event_inc_a: assert property (
		(event_mode && rise && ctrl.accum_edge_polarity && !cnt_wr)
		|=> accum_count == 16'($past(accum_count) + 16'h0001))
		else $error("rising edge not counted");
	// no gated count with timer off
	gate_idle_a: assert property (
		(gated_mode && !sys.timer_enable_bit && !cnt_wr)
		|=> $stable(accum_count))
		else $error("gated count without timer");
	disabled_hold_a: assert property (
		(!ctrl.accum_enable && !cnt_wr) |=> $stable(accum_count))
		else $error("count moved while disabled");
	clk_default_a: assert property (
		!ctrl.accum_enable |-> timer_count_tick == prescaler_tick)
		else $error("timer clock not prescaler");
	ovf_irq_a: assert property (
		(accum_overflow_flag && ctrl.accum_overflow_irq_en
		&& irq_mask[accum_pkg::OVF_BIT]) |=> irq)
		else $error("overflow irq missing");
	clear_guard_a: assert property (
		(accum_edge_flag && !sys.timer_enable_bit
		&& !ctrl.accum_enable && !fast_clear_now)
		|=> accum_edge_flag)
		else $error("flag cleared while disabled");
	fast_clear_a: assert property (
		(fast_clear_now && !ovf_event) |=> !accum_overflow_flag)
		else $error("fast clear failed");

	wrap_c: cover property (ovf_event);
	gated_c: cover property (gated_mode && accum_clock);
	irq_c: cover property ($rose(irq));
	fast_c: cover property (fast_clear_now && accum_edge_flag);

endmodule
`default_nettype wire

//--- test/pin_model.sv
// far-side model: an external source on the channel 7 input pin
// assumes one bench process calls its tasks, right after a clock edge
`default_nettype none
module pin_model (
	input  wire logic clk,
	output var  logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// pin driver, idle high, each level of a pulse held at least w cycles
	// ----------------------------------------------------------------
	initial pin = 1'b1;
	task automatic pulse(input int n, input int w);
		repeat (n) begin
			@(posedge clk);
			pin <= 1'b0;
			repeat (w) @(posedge clk);
			pin <= 1'b1;
			repeat (w) @(posedge clk);
		end
	endtask
	task automatic set(input logic v);
		@(posedge clk);
		pin <= v;
	endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the pulse accumulator
// assumes accum_pkg, the design and pin_model are compiled first
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// stimulus, bus master and checks
	// ----------------------------------------------------------------
	logic        clk, rst_b, cyc, stb, we, ack, irq, tc_tick, pin;
	logic        pre_tick = 1'b0;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [1:0]  pre_cnt = 2'h0;
	int          fail_count, n_tests;
	int          ticks = 0;

	pulse_accumulator_16bit u_dut (
		.clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.channel7_pin(pin), .prescaler_tick(pre_tick),
		.timer_count_tick(tc_tick), .irq(irq));
	pin_model u_pin (.clk(clk), .pin(pin));

	initial clk = 1'b0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		pre_cnt <= pre_cnt + 2'h1;
		pre_tick <= (pre_cnt == 2'h3);
		ticks <= ticks + int'(tc_tick);
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		chk("ack", 32'h1, {31'h0, ack});
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [9:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic rdc(input string nm, input logic [9:0] a,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, q);
	endtask

	task automatic t_reset;
		rdc("ctrl", accum_pkg::ADR_CTRL, 32'h0);
		rdc("count", accum_pkg::ADR_CNTW, 32'h0);
		rdc("count high", accum_pkg::ADR_CNTH, 32'h0);
		rdc("count low", accum_pkg::ADR_CNTL, 32'h0);
		rdc("flags", accum_pkg::ADR_FLAGS, 32'h0);
		rdc("unmapped", 10'h3FC, 32'h0);
		wr(accum_pkg::ADR_CNTH, 32'h12);
		wr(accum_pkg::ADR_CNTL, 32'h34);
		rdc("count bytes", accum_pkg::ADR_CNTW, 32'h1234);
		wr(accum_pkg::ADR_CNTW, 32'h0);
		rdc("count word", accum_pkg::ADR_CNTW, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_event;
		wr(accum_pkg::ADR_SYS, 32'h0);
		wr(accum_pkg::ADR_CTRL, 32'h40);
		u_pin.set(1'b0);
		repeat (6) @(posedge clk);
		rdc("fall count", accum_pkg::ADR_CNTW, 32'h1);
		u_pin.set(1'b1);
		u_pin.pulse(2, 4);
		rdc("count", accum_pkg::ADR_CNTW, 32'h3);
		rdc("edge flag", accum_pkg::ADR_FLAGS, 32'h1);
		wr(accum_pkg::ADR_CTRL, 32'h0);
		wr(accum_pkg::ADR_FLAGS, 32'h1);
		rdc("flag kept", accum_pkg::ADR_FLAGS, 32'h1);
		u_pin.pulse(2, 4);
		rdc("count off", accum_pkg::ADR_CNTW, 32'h3);
		wr(accum_pkg::ADR_IMASK, 32'h1);
		rdc("mask", accum_pkg::ADR_IMASK, 32'h1);
		chk("irq off", 32'h0, {31'h0, irq});
		wr(accum_pkg::ADR_CTRL, 32'h41);
		repeat (3) @(posedge clk);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(accum_pkg::ADR_FLAGS, 32'h1);
		rdc("istat edge", accum_pkg::ADR_ISTAT, 32'h1);
		rdc("flag clr", accum_pkg::ADR_FLAGS, 32'h0);
		chk("irq clr", 32'h0, {31'h0, irq});
		$display("test event done");
	endtask
	task automatic t_rise_ovf;
		wr(accum_pkg::ADR_CNTW, 32'hFFFF);
		wr(accum_pkg::ADR_CTRL, 32'h52);
		wr(accum_pkg::ADR_IMASK, 32'h2);
		u_pin.set(1'b0);
		repeat (6) @(posedge clk);
		rdc("no fall", accum_pkg::ADR_CNTW, 32'hFFFF);
		u_pin.set(1'b1);
		repeat (6) @(posedge clk);
		rdc("wrap", accum_pkg::ADR_CNTW, 32'h0);
		rdc("ovf flag", accum_pkg::ADR_FLAGS, 32'h3);
		chk("irq ovf", 32'h1, {31'h0, irq});
		wr(accum_pkg::ADR_CTRL, 32'h50);
		rdc("istat ovf", accum_pkg::ADR_ISTAT, 32'h2);
		chk("irq ovf off", 32'h0, {31'h0, irq});
		wr(accum_pkg::ADR_SYS, 32'h2);
		rdc("sys", accum_pkg::ADR_SYS, 32'h2);
		rdc("count high", accum_pkg::ADR_CNTH, 32'h0);
		rdc("fast clr", accum_pkg::ADR_FLAGS, 32'h0);
		$display("test rise and overflow done");
	endtask
	task automatic t_gated;
		for (int p = 0; p < 2; p++) begin
			wr(accum_pkg::ADR_SYS, 32'h0);
			u_pin.set(1'(p));
			wr(accum_pkg::ADR_CNTW, 32'h0);
			wr(accum_pkg::ADR_CTRL, (p != 0) ? 32'h70 : 32'h60);
			u_pin.set(~1'(p));
			repeat (200) @(posedge clk);
			rdc("gate idle", accum_pkg::ADR_CNTW, 32'h0);
			wr(accum_pkg::ADR_SYS, 32'h1);
			wr(accum_pkg::ADR_FLAGS, 32'h3);
			repeat (256) @(posedge clk);
			u_pin.set(1'(p));
			repeat (6) @(posedge clk);
			rd(accum_pkg::ADR_CNTW);
			chk("gate count", 32'h1, {31'h0, q >= 32'h3 && q <= 32'h5});
			rdc("trail flag", accum_pkg::ADR_FLAGS, 32'h1);
		end
		$display("test gated done");
	endtask
	task automatic t_clock;
		int t0;
		wr(accum_pkg::ADR_CTRL, 32'h04);
		t0 = ticks;
		repeat (40) @(posedge clk);
		chk("prescale off", 32'hA, 32'(ticks - t0));
		wr(accum_pkg::ADR_CTRL, 32'h40);
		t0 = ticks;
		repeat (40) @(posedge clk);
		chk("prescale on", 32'hA, 32'(ticks - t0));
		for (int s = 1; s < 4; s++) begin
			wr(accum_pkg::ADR_CNTW, (s == 1) ? 32'h0 :
				(s == 2) ? 32'hFE : 32'hFFFE);
			wr(accum_pkg::ADR_CTRL, 32'h40 | 32'(s << 2));
			t0 = ticks;
			u_pin.pulse(3, 4);
			chk("accum ticks", (s == 1) ? 32'h3 : 32'h1, 32'(ticks - t0));
		end
		$display("test clock select done");
	endtask

	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h0;
		sel = 4'hF;
		wdat = 32'h0;
		fail_count = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_reset;
		t_event;
		t_rise_ovf;
		t_gated;
		t_clock;
		results;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results;
	end
endmodule
`default_nettype wire
